// ===== hw/tm16_timer.v
// 16-bit timer with single-pulse and PWM modes behind a byte register port.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tm16_map.vh"
module tm16_timer
(
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire [3:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  input  wire       i_capture_input_one,
  input  wire       i_capture_input_two,
  input  wire       i_ext_clk,
  input  wire       i_halt,
  input  wire       i_wait,
  input  wire       i_irq_mask,
  output reg        o_wave_output_one,
  output reg        o_wave_output_one_oe,
  output reg        o_wave_output_two,
  output reg        o_wave_output_two_oe,
  output reg        o_irq,
  output reg        o_wake
);

////////////////////////////////////////////////////////////////////////////
reg  [7:0]  ctrl1_q;
reg  [7:0]  ctrl2_q;
reg  [15:0] cnt_q;
reg  [15:0] cap1_q;
reg  [15:0] cap2_q;
reg  [15:0] cmp1_q;
reg  [15:0] cmp2_q;
reg  [7:0]  cmp1_hi_q;
reg  [7:0]  cmp2_hi_q;
reg         cmp1_lock_q;
reg         cmp2_lock_q;
reg  [15:0] sh1_q;
reg  [15:0] sh2_q;
reg  [4:0]  flags_q;
reg  [4:0]  clr_arm_q;
reg         cap1_lock_q;
reg         cap2_lock_q;
reg  [1:0]  halt_arm_q;
reg         halt_q;
reg  [2:0]  pre_q;
reg  [2:0]  s1_q;
reg  [2:0]  s2_q;
reg  [2:0]  s3_q;
reg  [7:0]  rdata_d;
reg         tick;
wire [4:0]  flags_set;
wire [4:0]  flags_clr;
wire [2:0]  rise;
wire [2:0]  fall;
wire        single_on;
wire        pwm_on;
wire        edge1;
wire        edge2;
wire        ext_tick;
wire        run;
wire        halt_exit;
wire        m1;
wire        m2;
wire        trig;
wire        reload;
wire        cap1_take;
wire        cap2_take;
wire        irq_d;
wire        rd_flags;

////////////////////////////////////////////////////////////////////////////
// Pins pass two flops; the third stage only serves edge detection.
always @(posedge i_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    s1_q <= 3'h0;
    s2_q <= 3'h0;
    s3_q <= 3'h0;
  end
  else
  begin
    s1_q <= {i_ext_clk, i_capture_input_two, i_capture_input_one};
    s2_q <= s1_q;
    s3_q <= s2_q;
  end
end

assign rise = s2_q & ~s3_q;
assign fall = ~s2_q & s3_q;
assign edge1 = ctrl1_q[`TM16_B_EDGE1] ? rise[0] : fall[0];
assign edge2 = ctrl2_q[`TM16_B_EDGE2] ? rise[1] : fall[1];
assign ext_tick = ctrl2_q[`TM16_B_EXT_EDGE] ? rise[2] : fall[2];

assign pwm_on = ctrl2_q[`TM16_B_PWM];
assign single_on = ctrl2_q[`TM16_B_SINGLE] & ~pwm_on;
assign run = ~i_halt;
assign halt_exit = halt_q & ~i_halt;

////////////////////////////////////////////////////////////////////////////
// Prescaler, frozen with the counter during halt.
always @(posedge i_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    pre_q <= 3'h0;
  end
  else if (run)
  begin
    pre_q <= pre_q + 3'h1;
  end
end

always @*
begin
  case (ctrl2_q[`TM16_B_SRC_HI:`TM16_B_SRC_LO])
    `TM16_SRC_DIV4: tick = (pre_q[1:0] == 2'h3);
    `TM16_SRC_DIV2: tick = pre_q[0];
    `TM16_SRC_DIV8: tick = (pre_q == 3'h7);
    default:        tick = ext_tick;
  endcase
end

////////////////////////////////////////////////////////////////////////////
// Outside PWM the compare is inhibited while a high byte waits for its low.
assign m1 = run & tick & (cnt_q == sh1_q) & (pwm_on | ~cmp1_lock_q);
assign m2 = run & tick & (cnt_q == sh2_q) & (pwm_on | ~cmp2_lock_q);
assign trig = single_on & edge1 & run;
assign reload = trig | (pwm_on & m2);
assign cap1_take = edge1 & ~pwm_on & run & ~cap1_lock_q;
assign cap2_take = edge2 & run & ~cap2_lock_q;
assign rd_flags = i_rd & (i_addr == `TM16_A_FLAGS);

// Flag order: capture one, match one, overflow, capture two, match two.
assign flags_set[4] = cap1_take | (pwm_on & m2)
                    | (halt_exit & halt_arm_q[0]);
assign flags_set[3] = m1 & ~single_on & ~pwm_on;
assign flags_set[2] = run & tick & ~reload & (cnt_q == `TM16_CNT_MAX);
assign flags_set[1] = cap2_take | (halt_exit & halt_arm_q[1]);
assign flags_set[0] = m2 & ~pwm_on;

assign flags_clr[4] = clr_arm_q[4] & (i_rd | i_wr)
                    & (i_addr == `TM16_A_IC1L);
assign flags_clr[3] = clr_arm_q[3] & (i_rd | i_wr)
                    & (i_addr == `TM16_A_OC1L);
assign flags_clr[2] = clr_arm_q[2] & (i_rd | i_wr)
                    & (i_addr == `TM16_A_CNTL);
assign flags_clr[1] = clr_arm_q[1] & (i_rd | i_wr)
                    & (i_addr == `TM16_A_IC2L);
assign flags_clr[0] = clr_arm_q[0] & (i_rd | i_wr)
                    & (i_addr == `TM16_A_OC2L);

// A new event in the clearing cycle survives the clear.
always @(posedge i_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    flags_q   <= 5'h00;
    clr_arm_q <= 5'h00;
  end
  else
  begin
    flags_q <= flags_set | (flags_q & ~flags_clr);
    if (rd_flags)
    begin
      clr_arm_q <= flags_q;
    end
    else
    begin
      clr_arm_q <= clr_arm_q & ~flags_clr;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Counter and capture registers.
always @(posedge i_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    cnt_q  <= `TM16_CNT_RST;
    cap1_q <= 16'h0000;
    cap2_q <= 16'h0000;
  end
  else
  begin
    if (reload)
    begin
      cnt_q <= `TM16_CNT_RST;
    end
    else if (run & tick)
    begin
      cnt_q <= cnt_q + 16'h0001;
    end
    if (cap1_take | (halt_exit & halt_arm_q[0]))
    begin
      cap1_q <= cnt_q;
    end
    if (cap2_take | (halt_exit & halt_arm_q[1]))
    begin
      cap2_q <= cnt_q;
    end
  end
end

// Capture edges during halt are remembered and served on the way out.
always @(posedge i_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    halt_q     <= 1'b0;
    halt_arm_q <= 2'h0;
  end
  else
  begin
    halt_q <= i_halt;
    if (halt_exit)
    begin
      halt_arm_q <= 2'h0;
    end
    else if (i_halt)
    begin
      halt_arm_q <= halt_arm_q | {edge2, edge1 & ~pwm_on};
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Software side: control, compare buffers and capture read locks.
always @(posedge i_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    ctrl1_q     <= `TM16_CTRL_RST;
    ctrl2_q     <= `TM16_CTRL_RST;
    cmp1_q      <= `TM16_OC_RST;
    cmp2_q      <= `TM16_OC_RST;
    cmp1_hi_q   <= 8'h80;
    cmp2_hi_q   <= 8'h80;
    cmp1_lock_q <= 1'b0;
    cmp2_lock_q <= 1'b0;
    cap1_lock_q <= 1'b0;
    cap2_lock_q <= 1'b0;
  end
  else
  begin
    if (i_wr)
    begin
      if (i_addr == `TM16_A_CTRL1)
      begin
        ctrl1_q <= i_wdata;
      end
      else if (i_addr == `TM16_A_CTRL2)
      begin
        ctrl2_q <= i_wdata;
      end
      else if (i_addr == `TM16_A_OC1H)
      begin
        cmp1_hi_q   <= i_wdata;
        cmp1_lock_q <= 1'b1;
      end
      else if (i_addr == `TM16_A_OC1L)
      begin
        cmp1_q      <= {cmp1_hi_q, i_wdata};
        cmp1_lock_q <= 1'b0;
      end
      else if (i_addr == `TM16_A_OC2H)
      begin
        cmp2_hi_q   <= i_wdata;
        cmp2_lock_q <= 1'b1;
      end
      else if (i_addr == `TM16_A_OC2L)
      begin
        cmp2_q      <= {cmp2_hi_q, i_wdata};
        cmp2_lock_q <= 1'b0;
      end
    end
    if (i_rd)
    begin
      if (i_addr == `TM16_A_IC1H)
      begin
        cap1_lock_q <= 1'b1;
      end
      else if (i_addr == `TM16_A_IC1L)
      begin
        cap1_lock_q <= 1'b0;
      end
      else if (i_addr == `TM16_A_IC2H)
      begin
        cap2_lock_q <= 1'b1;
      end
      else if (i_addr == `TM16_A_IC2L)
      begin
        cap2_lock_q <= 1'b0;
      end
    end
  end
end

// Shadows track the buffers outside PWM; in PWM they move at period end.
always @(posedge i_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    sh1_q <= `TM16_OC_RST;
    sh2_q <= `TM16_OC_RST;
  end
  else if (!pwm_on)
  begin
    sh1_q <= cmp1_q;
    sh2_q <= cmp2_q;
  end
  else if (m2)
  begin
    sh1_q <= cmp1_q;
    sh2_q <= cmp2_q;
  end
end

////////////////////////////////////////////////////////////////////////////
// Waveform pins; the level latch runs even while the pin is released.
always @(posedge i_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    o_wave_output_one    <= 1'b0;
    o_wave_output_two    <= 1'b0;
    o_wave_output_one_oe <= 1'b0;
    o_wave_output_two_oe <= 1'b0;
  end
  else
  begin
    o_wave_output_one_oe <= ctrl2_q[`TM16_B_PIN1_EN];
    o_wave_output_two_oe <= ctrl2_q[`TM16_B_PIN2_EN];
    if (trig)
    begin
      o_wave_output_one <= ctrl1_q[`TM16_B_DURING];
    end
    else if (pwm_on & m2)
    begin
      o_wave_output_one <= ctrl1_q[`TM16_B_DURING];
    end
    else if ((single_on | pwm_on) & m1)
    begin
      o_wave_output_one <= ctrl1_q[`TM16_B_AFTER];
    end
    else if (!single_on & !pwm_on & (m1 | ctrl1_q[`TM16_B_FORCE1]))
    begin
      o_wave_output_one <= ctrl1_q[`TM16_B_AFTER];
    end
    // Compare two drives its pin only in plain compare operation.
    if (!single_on & !pwm_on & (m2 | ctrl1_q[`TM16_B_FORCE2]))
    begin
      o_wave_output_two <= ctrl1_q[`TM16_B_DURING];
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Shared request; flags cannot rise in halt, so halt is never left by it.
assign irq_d = ~i_irq_mask
             & ((ctrl1_q[`TM16_B_CAP_IE] & (flags_q[4] | flags_q[1]))
             | (ctrl1_q[`TM16_B_MATCH_IE] & (flags_q[3] | flags_q[0]))
             | (ctrl1_q[`TM16_B_OVF_IE] & flags_q[2]));

always @(posedge i_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    o_irq  <= 1'b0;
    o_wake <= 1'b0;
  end
  else
  begin
    o_irq  <= irq_d;
    o_wake <= irq_d & i_wait & ~i_halt;
  end
end

////////////////////////////////////////////////////////////////////////////
always @*
begin
  rdata_d = 8'h00;
  if (i_addr == `TM16_A_CTRL1)
    rdata_d = ctrl1_q;
  else if (i_addr == `TM16_A_CTRL2)
    rdata_d = ctrl2_q;
  else if (i_addr == `TM16_A_FLAGS)
    rdata_d = {flags_q, 3'h0};
  else if (i_addr == `TM16_A_IC1H)
    rdata_d = cap1_q[15:8];
  else if (i_addr == `TM16_A_IC1L)
    rdata_d = cap1_q[7:0];
  else if (i_addr == `TM16_A_IC2H)
    rdata_d = cap2_q[15:8];
  else if (i_addr == `TM16_A_IC2L)
    rdata_d = cap2_q[7:0];
  else if (i_addr == `TM16_A_OC1H)
    rdata_d = cmp1_q[15:8];
  else if (i_addr == `TM16_A_OC1L)
    rdata_d = cmp1_q[7:0];
  else if (i_addr == `TM16_A_OC2H)
    rdata_d = cmp2_q[15:8];
  else if (i_addr == `TM16_A_OC2L)
    rdata_d = cmp2_q[7:0];
  else if (i_addr == `TM16_A_CNTH)
    rdata_d = cnt_q[15:8];
  else if (i_addr == `TM16_A_CNTL)
    rdata_d = cnt_q[7:0];
end

// Read data stand for one cycle per read-strobe cycle, zero otherwise.
always @(posedge i_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    o_rdata <= 8'h00;
  end
  else
  begin
    o_rdata <= i_rd ? rdata_d : 8'h00;
  end
end

endmodule
`default_nettype wire

// ===== hw/tm16_map.vh
// Register offsets, field positions and reset values of the 16-bit timer.
// Functional notes
// - Single-pulse trigger edge copies counter to capture one and sets its flag.
// - Trigger edge reloads counter to fffc and drives during-pulse level.
// - Single-pulse match with compare one drives after-pulse level.
// - Single-pulse mode never sets match flag one; match flag two works.
// - Both mode bits set means PWM only.
// - Single-pulse: input two still captures; every input one edge restarts.
// - Single-pulse: compare two flags elapsed time but drives no pin.
// - PWM: compare values reach shadows only at period end.
// - Compare high byte write blocks transfer until low byte written.
// - PWM: compare never inhibited.
// - PWM: match one gives after-pulse level, match two during-pulse level.
// - PWM: match two reloads counter to fffc.
// - PWM: match flags never set.
// - PWM: match two sets capture flag one.
// - PWM: input one disconnected; input two still captures.
// - Timer runs in wait; enabled interrupt wakes from wait.
// - Halt freezes counter and registers; resume from held value.
// - Capture edge in halt arms; exit sets flag, captures counter.
// - No timer event wakes from halt.
// - One shared interrupt, each event gated by enable and global mask.
// - Capture flag clears after status read then low byte access.
// - Tick is clock over 2, 4, 8 or external edge.
// - Tick select 00 div4, 01 div2, 10 div8, 11 external.
// - Pin enable clear releases wave pin; compare keeps running.
`ifndef TM16_MAP_VH
`define TM16_MAP_VH
`define TM16_A_CTRL1 4'h0
`define TM16_A_CTRL2 4'h1
`define TM16_A_FLAGS 4'h2
`define TM16_A_IC1H  4'h3
`define TM16_A_IC1L  4'h4
`define TM16_A_IC2H  4'h5
`define TM16_A_IC2L  4'h6
`define TM16_A_OC1H  4'h7
`define TM16_A_OC1L  4'h8
`define TM16_A_OC2H  4'h9
`define TM16_A_OC2L  4'ha
`define TM16_A_CNTH  4'hb
`define TM16_A_CNTL  4'hc
`define TM16_B_CAP_IE   7
`define TM16_B_MATCH_IE 6
`define TM16_B_OVF_IE   5
`define TM16_B_FORCE2   4
`define TM16_B_FORCE1   3
`define TM16_B_DURING   2
`define TM16_B_EDGE1    1
`define TM16_B_AFTER    0
`define TM16_B_PIN1_EN  7
`define TM16_B_PIN2_EN  6
`define TM16_B_SINGLE   5
`define TM16_B_PWM      4
`define TM16_B_SRC_HI   3
`define TM16_B_SRC_LO   2
`define TM16_B_EDGE2    1
`define TM16_B_EXT_EDGE 0
`define TM16_SRC_DIV4 2'h0
`define TM16_SRC_DIV2 2'h1
`define TM16_SRC_DIV8 2'h2
`define TM16_CTRL_RST 8'h00
`define TM16_CNT_RST  16'hfffc
`define TM16_CNT_MAX  16'hffff
`define TM16_OC_RST   16'h8000
`endif

// ===== testbench/tm16_checker.sv
// Port checker for the 16-bit timer.
`timescale 1ns/1ps
`default_nettype none
module tm16_checker
(
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_halt,
  input wire logic       i_wait,
  input wire logic       i_irq_mask,
  input wire logic       o_wave_output_one,
  input wire logic       o_wave_output_one_oe,
  input wire logic       o_irq,
  input wire logic       o_wake
);
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  logic       frd;
  ////////////////////////////////////////////////////////////////////////////
  // Control bytes are mirrored from the bus so modes are known here.
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      c1_q <= 8'h00;
      c2_q <= 8'h00;
    end
    else if (i_wr && i_addr == 4'h0)
      c1_q <= i_wdata;
    else if (i_wr && i_addr == 4'h1)
      c2_q <= i_wdata;
  assign frd = i_rd && i_addr == 4'h2;
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_halted;
    i_halt && !i_wr ##1 i_halt && !i_wr;
  endsequence
  AST_WAKE_HALT: assert property ($past(i_halt) |-> !o_wake)
    else $error("wake raised in halt");
  AST_WAKE_WAIT: assert property (o_wake |-> $past(i_wait))
    else $error("wake without wait");
  AST_IRQ_MASK: assert property (o_irq |-> !$past(i_irq_mask))
    else $error("irq while masked");
  AST_IRQ_EN: assert property (o_irq |-> $past(c1_q[7:5]) != 3'h0)
    else $error("irq with no enable");
  AST_PIN_OE: assert property (o_wave_output_one_oe == $past(c2_q[7]))
    else $error("pin enable wrong");
  AST_PWM_NOMATCH: assert property ($past(frd && c2_q[4]) |->
    o_rdata[6] == 1'b0 && o_rdata[3] == 1'b0) else $error("match flag in pwm");
  AST_SP_NOMATCH: assert property ($past(frd && c2_q[5] && !c2_q[4]) |->
    o_rdata[6] == 1'b0) else $error("match flag one in single pulse");
  AST_HALT_FREEZE: assert property (s_halted |=> $stable(o_wave_output_one))
    else $error("wave moved in halt");
endmodule
bind tm16_timer tm16_checker u_tm16_checker (.i_clk, .i_rst_n, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .i_halt, .i_wait, .i_irq_mask,
  .o_wave_output_one, .o_wave_output_one_oe, .o_irq, .o_wake);
`default_nettype wire

// ===== testbench/tm16_pins.sv
// Pin-side model: drives capture and tick pins, times the wave pin.
`timescale 1ns/1ps
`default_nettype none
module tm16_pins
(
  input  wire logic i_clk,
  input  wire logic i_wave,
  input  wire logic i_oe,
  output var  logic o_cap1,
  output var  logic o_cap2,
  output var  logic o_ext
);
  wire pin;
  // A released pin floats to its pull-up, never the last level.
  assign pin = i_oe ? i_wave : 1'b1;
  initial
  begin
    o_cap1 = 1'b0;
    o_cap2 = 1'b0;
    o_ext  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic hit(input int p, input int w);
    @(posedge i_clk);
    if (p == 1) o_cap1 <= 1'b1;
    else o_cap2 <= 1'b1;
    repeat (w) @(posedge i_clk);
    o_cap1 <= 1'b0;
    o_cap2 <= 1'b0;
  endtask
  // The tick pin stays still between bursts.
  task automatic ext(input int n);
    repeat (n)
    begin
      @(posedge i_clk);
      o_ext <= 1'b1;
      repeat (3) @(posedge i_clk);
      o_ext <= 1'b0;
      repeat (2) @(posedge i_clk);
    end
  endtask
  // Sampled mid-cycle so the registered pin has settled.
  task automatic run(input logic v, output int n);
    for (int k = 0; k < 400 && pin === v; k++) @(negedge i_clk);
    for (int k = 0; k < 400 && pin !== v; k++) @(negedge i_clk);
    for (n = 0; n < 400 && pin === v; n++) @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

// ===== testbench/test_tm16_timer.sv
// Self-checking bench for the 16-bit timer pulse and PWM modes.
`timescale 1ns/1ps
`default_nettype none
module test_tm16_timer;
  logic       i_clk = 1'b0;
  logic       i_rst_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic       i_halt = 1'b0;
  logic       i_wait = 1'b0;
  logic       i_irq_mask = 1'b0;
  wire        wave, wave2, oe, o_irq, o_wake, cap1, cap2, ext;
  wire  [7:0] o_rdata;
  int         fails = 0;
  int         checked = 0;
  int         n;
  logic [7:0] x, y, f;
  always #20 i_clk = ~i_clk;
  tm16_timer u_tm16_timer (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_capture_input_one(cap1),
    .i_capture_input_two(cap2), .i_ext_clk(ext), .i_halt, .i_wait,
    .i_irq_mask, .o_wave_output_one(wave), .o_wave_output_one_oe(oe),
    .o_wave_output_two(wave2), .o_wave_output_two_oe(), .o_irq, .o_wake);
  tm16_pins u_tm16_pins (.i_clk, .i_wave(wave), .i_oe(oe), .o_cap1(cap1),
    .o_cap2(cap2), .o_ext(ext));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH time %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rst;
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_ticks;
    for (int s = 0; s < 3; s++)
    begin
      rst;
      wr(4'h1, 8'(s << 2));
      rd(4'hc, x);
      repeat (62) @(posedge i_clk);
      rd(4'hc, y);
      chk(8'(y - x), s == 0 ? 16'h10 : s == 1 ? 16'h20 : 16'h08);
    end
    wr(4'h1, 8'h0d);
    rd(4'hc, x);
    u_tm16_pins.ext(10);
    repeat (8) @(posedge i_clk);
    rd(4'hc, y);
    chk(8'(y - x), 16'h0a);
    rd(4'hd, x);
    chk(x, 16'h00);
    $display("ticks done");
  endtask
  task automatic t_single;
    rst;
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h10);
    wr(4'h9, 8'h00);
    wr(4'ha, 8'h08);
    wr(4'h0, 8'h06);
    wr(4'h1, 8'ha6);
    fork
      u_tm16_pins.hit(1, 3);
      u_tm16_pins.run(1'b1, n);
    join
    chk(16'(n == 41 || n == 42), 16'h1);
    u_tm16_pins.hit(2, 3);
    repeat (8) @(posedge i_clk);
    rd(4'h2, f);
    chk(f[7], 16'h1);
    chk(f[6], 16'h0);
    chk(f[4], 16'h1);
    chk(f[3], 16'h1);
    chk(wave2, 16'h0);
    rd(4'h4, x);
    rd(4'h2, f);
    chk(f[7], 16'h0);
    $display("single pulse done");
  endtask
  task automatic t_pwm;
    rst;
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h08);
    wr(4'h9, 8'h00);
    wr(4'ha, 8'h20);
    wr(4'h0, 8'h04);
    wr(4'h1, 8'hb4);
    u_tm16_pins.run(1'b1, n);
    chk(16'(n), 16'd26);
    u_tm16_pins.run(1'b0, n);
    chk(16'(n), 16'd48);
    wr(4'h7, 8'h7f);
    u_tm16_pins.run(1'b1, n);
    u_tm16_pins.run(1'b1, n);
    chk(16'(n), 16'd26);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h10);
    u_tm16_pins.run(1'b1, n);
    fork
      u_tm16_pins.hit(1, 3);
      u_tm16_pins.run(1'b1, n);
    join
    chk(16'(n), 16'd42);
    rd(4'h4, x);
    chk(x, 16'h0);
    rd(4'h2, f);
    chk(f[7], 16'h1);
    chk({f[6], f[3]}, 16'h0);
    u_tm16_pins.hit(2, 3);
    repeat (8) @(posedge i_clk);
    rd(4'h2, f);
    chk(f[4], 16'h1);
    $display("pwm done");
  endtask
  task automatic t_halt;
    rst;
    wr(4'h0, 8'h80);
    wr(4'h1, 8'h02);
    i_halt <= 1'b1;
    rd(4'hc, x);
    repeat (20) @(posedge i_clk);
    rd(4'hc, y);
    chk(y, x);
    u_tm16_pins.hit(2, 3);
    repeat (8) @(posedge i_clk);
    rd(4'h2, f);
    chk(f[4], 16'h0);
    chk(o_wake, 16'h0);
    @(posedge i_clk);
    i_halt <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd(4'h2, f);
    chk(f[4], 16'h1);
    @(posedge i_clk);
    i_wait <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1 chk(o_wake, 16'h1);
    @(posedge i_clk);
    i_halt <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1 chk(o_wake, 16'h0);
    @(posedge i_clk);
    i_halt <= 1'b0;
    i_irq_mask <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1 chk(o_irq, 16'h0);
    $display("halt and wait done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    t_ticks;
    t_single;
    t_pwm;
    t_halt;
    final_report;
  end
  // The tests need about a thousand cycles; this leaves ample margin.
  initial
  begin
    repeat (20000) @(posedge i_clk);
    fails++;
    final_report;
  end
endmodule
`default_nettype wire
